// ---- shared/pft_pkg.sv ----
// Purpose: Constants shared by the temperature and 4-pair fault register block
// Assumes: Core clock of 25 MHz; command codes arrive from the serial front end
// Notes:   Bit pairs hold the ch1/2 port in the low bit, the ch3/4 port in the high bit
package pft_pkg;
   // =====================================================================
   // Command codes and reset values
   localparam logic [7:0] CMD_DIE_TEMP      = 8'h2c;
   localparam logic [7:0] CMD_FAULT_CFG     = 8'h2d;
   localparam logic [7:0] DIE_TEMP_RST      = 8'h00;
   localparam logic [7:0] FAULT_CFG_RST     = 8'h00;
   localparam logic [7:0] UNMAPPED_RDATA    = 8'h00;

   // =====================================================================
   // Fault configuration field positions (low bit of each pair)
   localparam int CFG_CURLIM_LSB = 6;
   localparam int CFG_PCUT_LSB   = 4;
   localparam int CFG_SUMEN_LSB  = 2;
   localparam int CFG_DISC_LSB   = 0;

   // =====================================================================
   // Temperature code scale, milli-degrees Celsius
   localparam int TEMP_OFFSET_MDEGC = -20000;
   localparam int TEMP_STEP_MDEGC   = 652;
   localparam int TEMP_FULL_MDEGC   = 146200;

   // =====================================================================
   // Timing
   localparam int SYS_CLK_PERIOD_NS  = 40;
   localparam int TEMP_REFRESH_MS    = 1000;
   localparam int TEMP_REFRESH_CYC   = TEMP_REFRESH_MS * 1000000 / SYS_CLK_PERIOD_NS;
   localparam int TEMP_CNT_W         = 25;

   // Operating modes of the controller
   typedef enum logic [1:0] {
      PFT_MODE_MANUAL,
      PFT_MODE_SEMI,
      PFT_MODE_AUTO
   } pft_mode_e;
endpackage : pft_pkg

// ---- shared/pft_port_if.sv ----
// Purpose: Carries one 4-pair port's settings, faults and channel-off requests
// Assumes: Index 0 is the odd channel of the pair, index 1 the even one
// Notes:   Combinational only; the top registers every result
`timescale 1ns/10ps
interface pft_port_if;
   logic       curlim_group_off;
   logic       powercut_group_off;
   logic       summed_powercut_en;
   logic [1:0] current_limit_fault;
   logic [1:0] powercut2_fault;
   logic       summed_powercut_fault;
   logic [1:0] chan_off;

   modport ctrl (output curlim_group_off, output powercut_group_off, output summed_powercut_en,
                 output current_limit_fault, output powercut2_fault, output summed_powercut_fault,
                 input chan_off);
   modport unit (input curlim_group_off, input powercut_group_off, input summed_powercut_en,
                 input current_limit_fault, input powercut2_fault, input summed_powercut_fault,
                 output chan_off);
endinterface : pft_port_if

// ---- verilog/pft_port_fault.sv ----
// Purpose: Decides which channels of one 4-pair port must be turned off
// Assumes: Fault inputs are already in the core clock domain
// Notes:   Pure combinational; the caller registers the result
`timescale 1ns/10ps
module pft_port_fault (
   // Port settings, faults and result
   pft_port_if.unit port
);
   // =====================================================================
   // Channel-off decision
   always_comb begin
      port.chan_off = port.current_limit_fault | port.powercut2_fault;
      // Grouping spreads a fault on either channel to both
      if (port.curlim_group_off && (|port.current_limit_fault)) begin
         port.chan_off = 2'h3;
      end
      if (port.powercut_group_off && (|port.powercut2_fault)) begin
         port.chan_off = 2'h3;
      end
      // Summed policing only acts when enabled; current-limit path above never depends on it
      if (port.summed_powercut_en && port.summed_powercut_fault) begin
         port.chan_off = 2'h3;
      end
   end
endmodule // pft_port_fault

// ---- verilog/pft_regs.sv ----
// Purpose: Die temperature and 4-pair fault configuration registers with fault grouping
// Assumes: Command port driven by the serial front end on i_sys_clk
// Notes:   Temperature is sampled from the converter on an internal one-second tick
//
// What this block does
// - Read-only temperature at 2Ch, resets zero
// - Temperature register holds full 8-bit result
// - Temperature refreshed about once per second
// - Code N means -20 plus N*0.652 C
// - Bits 7,6 current-limit grouping, writable, reset zero
// - Grouping one: current-limit fault turns off both
// - Grouping zero: only faulting channel turns off
// - Bits 5,4 power-cut grouping, writable, reset zero
// - Grouping one: power-cut fault turns off both
// - Grouping zero: only power-cut channel turns off
// - Auto mode sets both grouping bits after turn-on
// - Bits 3,2 enable summed power-cut policing
// - Zero disables summed; current-limit monitoring continues
// - Auto and semi-auto set summed enable after turn-on
// - Bits 1,0 pick disconnect threshold, one lower
`timescale 1ns/10ps
module pft_regs #(
   parameter int unsigned P_TEMP_REFRESH_CYC = pft_pkg::TEMP_REFRESH_CYC
) (
   // Clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst_n,
   // Command port from the serial front end
   input  wire logic [7:0] i_reg_addr,
   input  wire logic       i_reg_wr,
   input  wire logic       i_reg_rd,
   input  wire logic [7:0] i_reg_wdata,
   output logic      [7:0] o_reg_rdata,
   output logic            o_reg_rvalid,
   // Temperature converter result
   input  wire logic [7:0] i_temp_code,
   // Port state from the controller core
   input  wire logic [1:0] i_mode,
   input  wire logic [1:0] i_fourpair_ss_on,
   input  wire logic [3:0] i_current_limit_fault,
   input  wire logic [3:0] i_powercut2_fault,
   input  wire logic [1:0] i_summed_powercut_fault,
   // Results to the power path
   output logic      [3:0] o_chan_off,
   output logic      [1:0] o_summed_powercut_en,
   output logic      [1:0] o_disconnect_thresh_sel
);
   // =====================================================================
   // Reset release synchroniser
   logic rst_meta_reg;
   logic rst_n_sync;

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta_reg <= 1'b0;
         rst_n_sync   <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_sync   <= rst_meta_reg;
      end
   end

   // =====================================================================
   // Register state
   logic [pft_pkg::TEMP_CNT_W-1:0] tick_cnt_reg, tick_cnt_next;
   logic                           refresh;
   logic [7:0] temp_code_reg, temp_code_next;
   logic [7:0] fault_cfg_reg, fault_cfg_next;
   logic [7:0] rdata_reg, rdata_next;
   logic       rvalid_reg, rvalid_next;
   logic [3:0] chan_off_reg, chan_off_next;
   logic [1:0] auto_set, semi_set;
   logic       mode_auto, mode_semi;

   assign mode_auto = (i_mode == pft_pkg::PFT_MODE_AUTO);
   assign mode_semi = (i_mode == pft_pkg::PFT_MODE_SEMI);
   assign auto_set  = mode_auto ? i_fourpair_ss_on : 2'h0;
   assign semi_set  = (mode_auto || mode_semi) ? i_fourpair_ss_on : 2'h0;
   assign refresh   = (tick_cnt_reg == pft_pkg::TEMP_CNT_W'(P_TEMP_REFRESH_CYC - 1));

   // =====================================================================
   // Port fault units, one per 4-pair port
   pft_port_if port_bus[2] ();

   for (genvar p = 0; p < 2; p++) begin : g_port
      // Low bit of each pair is the ch1/2 port
      assign port_bus[p].curlim_group_off      = fault_cfg_reg[pft_pkg::CFG_CURLIM_LSB + p];
      assign port_bus[p].powercut_group_off    = fault_cfg_reg[pft_pkg::CFG_PCUT_LSB + p];
      assign port_bus[p].summed_powercut_en    = fault_cfg_reg[pft_pkg::CFG_SUMEN_LSB + p];
      assign port_bus[p].current_limit_fault   = i_current_limit_fault[2*p +: 2];
      assign port_bus[p].powercut2_fault       = i_powercut2_fault[2*p +: 2];
      assign port_bus[p].summed_powercut_fault = i_summed_powercut_fault[p];
      assign chan_off_next[2*p +: 2]           = port_bus[p].chan_off;

      pft_port_fault u_port (
         .port (port_bus[p])
      );
   end

   // =====================================================================
   // Next-state logic for registers and read answer
   always_comb begin
      // Free-running tick; the host never has to ask for a conversion
      tick_cnt_next  = refresh ? '0 : tick_cnt_reg + 1'b1;
      temp_code_next = refresh ? i_temp_code : temp_code_reg;
      fault_cfg_next = fault_cfg_reg;
      if (i_reg_wr && (i_reg_addr == pft_pkg::CMD_FAULT_CFG)) begin
         fault_cfg_next = i_reg_wdata;
      end
      // Hardware set wins over a host write in the same cycle
      for (int p = 0; p < 2; p++) begin
         if (auto_set[p]) begin
            fault_cfg_next[pft_pkg::CFG_CURLIM_LSB + p] = 1'b1;
            fault_cfg_next[pft_pkg::CFG_PCUT_LSB + p]   = 1'b1;
         end
         if (semi_set[p]) begin
            fault_cfg_next[pft_pkg::CFG_SUMEN_LSB + p] = 1'b1;
         end
      end
      rvalid_next = i_reg_rd;
      rdata_next  = rdata_reg;
      if (i_reg_rd) begin
         case (i_reg_addr)
            pft_pkg::CMD_DIE_TEMP:  rdata_next = temp_code_reg;
            pft_pkg::CMD_FAULT_CFG: rdata_next = fault_cfg_reg;
            default:                rdata_next = pft_pkg::UNMAPPED_RDATA;
         endcase
      end
   end

   // Registers; writes to the temperature code are simply dropped
   always_ff @(posedge i_sys_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         tick_cnt_reg  <= '0;
         temp_code_reg <= pft_pkg::DIE_TEMP_RST;
         fault_cfg_reg <= pft_pkg::FAULT_CFG_RST;
         rdata_reg     <= pft_pkg::UNMAPPED_RDATA;
         rvalid_reg    <= 1'b0;
         chan_off_reg  <= 4'h0;
      end else begin
         tick_cnt_reg  <= tick_cnt_next;
         temp_code_reg <= temp_code_next;
         fault_cfg_reg <= fault_cfg_next;
         rdata_reg     <= rdata_next;
         rvalid_reg    <= rvalid_next;
         chan_off_reg  <= chan_off_next;
      end
   end

   // =====================================================================
   // Outputs straight from flops
   assign o_reg_rdata             = rdata_reg;
   assign o_reg_rvalid            = rvalid_reg;
   assign o_chan_off              = chan_off_reg;
   assign o_summed_powercut_en    = fault_cfg_reg[pft_pkg::CFG_SUMEN_LSB +: 2];
   assign o_disconnect_thresh_sel = fault_cfg_reg[pft_pkg::CFG_DISC_LSB +: 2];

   // =====================================================================
   // Checks
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!rst_n_sync);

   property p_temp_read;
      i_reg_rd && i_reg_addr == pft_pkg::CMD_DIE_TEMP |=> o_reg_rvalid && o_reg_rdata == $past(temp_code_reg);
   endproperty
   a_temp_read: assert property (p_temp_read) else $error("temperature read wrong");

   property p_temp_load;
      refresh |=> temp_code_reg == $past(i_temp_code);
   endproperty
   a_temp_load: assert property (p_temp_load) else $error("temperature not loaded");

   property p_temp_hold;
      !refresh |=> $stable(temp_code_reg);
   endproperty
   a_temp_hold: assert property (p_temp_hold) else $error("temperature changed off tick");

   property p_cfg_write;
      i_reg_wr && i_reg_addr == pft_pkg::CMD_FAULT_CFG && i_fourpair_ss_on == 2'h0
         |=> fault_cfg_reg == $past(i_reg_wdata);
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

   property p_curlim_group;
      fault_cfg_reg[pft_pkg::CFG_CURLIM_LSB] && i_current_limit_fault[0] |=> o_chan_off[1:0] == 2'h3;
   endproperty
   a_curlim_group: assert property (p_curlim_group) else $error("grouped current limit missed");

   property p_curlim_single;
      !fault_cfg_reg[pft_pkg::CFG_CURLIM_LSB] && i_current_limit_fault[1:0] == 2'h1
         && i_powercut2_fault[1:0] == 2'h0 && !i_summed_powercut_fault[0] |=> o_chan_off[1:0] == 2'h1;
   endproperty
   a_curlim_single: assert property (p_curlim_single) else $error("single current limit wrong");

   property p_pcut_group;
      fault_cfg_reg[pft_pkg::CFG_PCUT_LSB + 1] && i_powercut2_fault[3] |=> o_chan_off[3:2] == 2'h3;
   endproperty
   a_pcut_group: assert property (p_pcut_group) else $error("grouped power cut missed");

   property p_pcut_single;
      !fault_cfg_reg[pft_pkg::CFG_PCUT_LSB + 1] && i_powercut2_fault[3:2] == 2'h2
         && i_current_limit_fault[3:2] == 2'h0 && !i_summed_powercut_fault[1] |=> o_chan_off[3:2] == 2'h2;
   endproperty
   a_pcut_single: assert property (p_pcut_single) else $error("single power cut wrong");

   property p_auto_set;
      mode_auto && i_fourpair_ss_on[0] |=> fault_cfg_reg[pft_pkg::CFG_CURLIM_LSB]
         && fault_cfg_reg[pft_pkg::CFG_PCUT_LSB] && fault_cfg_reg[pft_pkg::CFG_SUMEN_LSB];
   endproperty
   a_auto_set: assert property (p_auto_set) else $error("auto mode bits not set");

   property p_semi_set;
      mode_semi && i_fourpair_ss_on[1] |=> fault_cfg_reg[pft_pkg::CFG_SUMEN_LSB + 1];
   endproperty
   a_semi_set: assert property (p_semi_set) else $error("semi mode summed enable not set");

   property p_sum_off;
      !fault_cfg_reg[pft_pkg::CFG_SUMEN_LSB] && i_summed_powercut_fault[0]
         && i_current_limit_fault[1:0] == 2'h0 && i_powercut2_fault[1:0] == 2'h0 |=> o_chan_off[1:0] == 2'h0;
   endproperty
   a_sum_off: assert property (p_sum_off) else $error("disabled summed cut acted");

   property p_sum_on;
      o_summed_powercut_en[1] && i_summed_powercut_fault[1] |=> o_chan_off[3:2] == 2'h3;
   endproperty
   a_sum_on: assert property (p_sum_on) else $error("summed cut ignored");

   // Expected select comes from the bus write, not from the next-state logic
   property p_thresh;
      ##1 o_disconnect_thresh_sel == ($past(i_reg_wr && i_reg_addr == pft_pkg::CMD_FAULT_CFG)
         ? $past(i_reg_wdata[1:0]) : $past(o_disconnect_thresh_sel));
   endproperty
   a_thresh: assert property (p_thresh) else $error("threshold select wrong");
endmodule // pft_regs

// ---- tb/pft_host_model.sv ----
// Purpose: Host side of the command port, issuing single-byte reads and writes
// Assumes: Requests start on the falling edge and are taken on the next rising edge
// Notes:   Tasks are called from the bench; write data is scrambled once released
`timescale 1ns/10ps
module pft_host_model (
   // Clock
   input  wire logic       i_sys_clk,
   // Command port toward the registers
   output logic      [7:0] o_reg_addr,
   output logic            o_reg_wr,
   output logic            o_reg_rd,
   output logic      [7:0] o_reg_wdata,
   input  wire logic [7:0] i_reg_rdata,
   input  wire logic       i_reg_rvalid
);
   // =====================================================================
   // Idle port at time zero
   initial begin
      o_reg_addr = 8'h00;
      o_reg_wr = 1'b0;
      o_reg_rd = 1'b0;
      o_reg_wdata = 8'h00;
   end

   // One write: strobe held across exactly one rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] dat);
      @(negedge i_sys_clk);
      o_reg_addr = a;
      o_reg_wdata = dat;
      o_reg_wr = 1'b1;
      @(negedge i_sys_clk);
      o_reg_wr = 1'b0;
      o_reg_wdata = ~dat;  // Stale data must not look valid
   endtask

   // One read: answer is taken in the cycle after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [7:0] dat, output logic vld);
      @(negedge i_sys_clk);
      o_reg_addr = a;
      o_reg_rd = 1'b1;
      @(negedge i_sys_clk);
      o_reg_rd = 1'b0;
      vld = i_reg_rvalid;
      dat = i_reg_rdata;
   endtask
endmodule // pft_host_model

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the temperature and 4-pair fault registers
// Assumes: Refresh period shortened to 16 cycles
// Notes:   Inputs change on the falling edge; results checked on the next falling edge
`timescale 1ns/10ps
module testbench;
   localparam int REFRESH = 16;
   logic       clk;
   logic       rst_n;
   logic [7:0] addr, wdata, rdata, temp, cfg_m, d;
   logic       wr, rd, rvalid, v;
   logic [1:0] mode, ss_on, sumf, sum_en, thresh;
   logic [3:0] clf, pcf, chan_off;
   int         fails, checked, seed;

   pft_regs #(.P_TEMP_REFRESH_CYC(REFRESH)) uut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_reg_addr(addr),
      .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
      .i_temp_code(temp), .i_mode(mode), .i_fourpair_ss_on(ss_on), .i_current_limit_fault(clf),
      .i_powercut2_fault(pcf), .i_summed_powercut_fault(sumf), .o_chan_off(chan_off),
      .o_summed_powercut_en(sum_en), .o_disconnect_thresh_sel(thresh));

   pft_host_model host (.i_sys_clk(clk), .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_rd(rd),
      .o_reg_wdata(wdata), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid));

   // =====================================================================
   // Reference: channel off requests from config and faults
   function automatic logic [3:0] exp_off(input logic [7:0] c, input logic [3:0] cl, input logic [3:0] pc,
                                          input logic [1:0] sf);
      logic [3:0] r;
      r = cl | pc;
      for (int p = 0; p < 2; p++) begin
         if ((c[6+p] && |cl[2*p+:2]) || (c[4+p] && |pc[2*p+:2]) || (c[2+p] && sf[p])) begin
            r[2*p+:2] = 2'b11;
         end
      end
      return r;
   endfunction

   // Read answer must be valid and carry the expected byte
   task automatic chk_rd(input logic [7:0] got, input logic vld, input logic [7:0] exp);
      checked++;
      if ({vld, got} !== {1'b1, exp}) begin
         fails++;
         $display("mismatch t=%0t got=%h exp=%h", $time, {vld, got}, {1'b1, exp});
      end
   endtask

   // Power path outputs against the reference
   task automatic chk_out;
      logic [7:0] e;
      e = {exp_off(cfg_m, clf, pcf, sumf), cfg_m[3:0]};
      checked++;
      if ({chan_off, sum_en, thresh} !== e) begin
         fails++;
         $display("mismatch t=%0t got=%h exp=%h", $time, {chan_off, sum_en, thresh}, e);
      end
   endtask

   task automatic wrap_up;
      if (fails == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // =====================================================================
   // Clock, 40 ns period
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Watchdog: the sequence needs well under 1000 cycles
   initial begin
      #(40 * 5000);
      fails++;
      wrap_up();
   end

   // Main sequence
   initial begin
      fails = 0;
      checked = 0;
      seed = 32'h2124c753;
      rst_n = 1'b0;
      temp = 8'h00;
      mode = 2'h3;
      ss_on = 2'h0;
      clf = 4'h0;
      pcf = 4'h0;
      sumf = 2'h0;
      cfg_m = 8'h00;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      // Reset values, refused write and unmapped read
      host.rd(8'h2c, d, v);
      chk_rd(d, v, 8'h00);
      host.wr(8'h2c, 8'hff);
      host.rd(8'h2c, d, v);
      chk_rd(d, v, 8'h00);
      host.rd(8'h2d, d, v);
      chk_rd(d, v, 8'h00);
      host.rd(8'h2e, d, v);
      chk_rd(d, v, 8'h00);
      // Random configs and sparse faults in manual mode
      mode = 2'h0;
      repeat (40) begin
         cfg_m = 8'($random(seed));
         host.wr(8'h2d, cfg_m);
         host.rd(8'h2d, d, v);
         chk_rd(d, v, cfg_m);
         clf = 4'($random(seed) & $random(seed));
         pcf = 4'($random(seed) & $random(seed));
         sumf = 2'($random(seed));
         @(negedge clk);
         chk_out();
      end
      clf = 4'h0;
      pcf = 4'h0;
      sumf = 2'h0;
      // Automatic setting per mode and port; manual and none leave bits alone
      for (int m = 0; m < 4; m++) begin
         for (int p = 0; p < 2; p++) begin
            host.wr(8'h2d, 8'h00);
            mode = m[1:0];
            @(negedge clk);
            ss_on[p] = 1'b1;
            @(negedge clk);
            ss_on = 2'h0;
            cfg_m = (m == 2) ? (8'h54 << p) : (m == 1) ? (8'h04 << p) : 8'h00;
            host.rd(8'h2d, d, v);
            chk_rd(d, v, cfg_m);
            chk_out();
         end
      end
      // Temperature follows the converter after each refresh
      mode = 2'h0;
      repeat (2) begin
         temp = 8'($random(seed));
         repeat (REFRESH + 4) @(negedge clk);
         host.rd(8'h2c, d, v);
         chk_rd(d, v, temp);
      end
      // Mid-run reset must clear a loaded temperature and a full config before the next tick
      host.wr(8'h2d, 8'hff);
      host.rd(8'h2d, d, v);
      chk_rd(d, v, 8'hff);
      @(negedge clk);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      host.rd(8'h2c, d, v);
      chk_rd(d, v, 8'h00);
      host.rd(8'h2d, d, v);
      chk_rd(d, v, 8'h00);
      cfg_m = 8'h00;
      chk_out();
      wrap_up();
   end
endmodule // testbench
